// File: pkg/sra_pkg.sv
package sra_pkg;
  localparam int NUM_REGS = 32;
  localparam int ADDR_W = 5;
  // command byte layout
  localparam int CMD_ADDR_MSB = 7;
  localparam int CMD_ADDR_LSB = 3;
  localparam int CMD_ZERO_BIT = 2;
  localparam int CMD_DIR_BIT = 1;
  localparam int CMD_ACK_BIT = 0;
  // register numbers
  localparam logic [4:0] REG_FIFO_LAST = 5'h04;
  localparam logic [4:0] REG_ENDPOINT_STALL_CONTROL = 5'h09;
  localparam logic [4:0] REG_PIN_CONTROL = 5'h11;
  localparam logic [4:0] REG_REVISION = 5'h12;
  localparam logic [4:0] REG_INC_LAST = 5'h13;
  localparam logic [4:0] REG_IO_PINS_FIRST_BANK = 5'h14;
  localparam logic [4:0] REG_OPERATING_MODE_SELECT = 5'h1b;
  localparam logic [4:0] REG_LAST = 5'h1f;
  // field positions and reset values
  localparam int ACK_BIT_POS = 6;
  localparam int HOST_BIT_POS = 0;
  localparam int FULL_DUPLEX_BIT_POS = 4;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [31:0] PERIPH_VALID_MAP = 32'h09ff_ffff;
  localparam logic [31:0] HOST_VALID_MAP = 32'hffe0_0fff;
  localparam logic [31:0] READ_ONLY_MAP = 32'h000c_0000;
  // controller apb map
  localparam logic [11:0] OFS_CMD = 12'h000;
  localparam logic [11:0] OFS_DATA = 12'h004;
  localparam logic [11:0] OFS_CFG = 12'h008;
  localparam logic [11:0] OFS_STAT = 12'h00c;
  localparam logic [11:0] OFS_RX = 12'h010;
  localparam int CMD_NBYTES_LSB = 8;
  localparam int CMD_START_BIT = 16;
  localparam logic [2:0] MAX_DATA_BYTES = 3'h4;
  localparam int CFG_HALF_BIT = 0;
  localparam int CFG_DIV_LSB = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_SB_LSB = 8;
  // timing
  localparam int PCLK_PERIOD_NS = 8;
  localparam int SCLK_PERIOD_NS = 160;
  localparam int SCLK_HALF_CYCLES = SCLK_PERIOD_NS / (2 * PCLK_PERIOD_NS);
  localparam logic [7:0] DIV_RESET = 8'(SCLK_HALF_CYCLES);
  localparam logic [7:0] DIV_MIN = 8'h08;
endpackage

// File: pkg/sra_spi_if.sv
interface sra_spi_if;
  logic sclk;
  logic ss_n;
  logic m_mosi_o;
  logic m_mosi_oe_n;
  logic s_mosi_o;
  logic s_mosi_oe_n;
  logic s_miso_o;
  logic s_miso_oe_n;
  wire mosi;
  wire miso;
  // shared data line, master wins, pulled high when free
  assign mosi = !m_mosi_oe_n ? m_mosi_o : (!s_mosi_oe_n ? s_mosi_o : 1'b1);
  assign miso = !s_miso_oe_n ? s_miso_o : 1'b1;
  modport master (output sclk, output ss_n, output m_mosi_o, output m_mosi_oe_n,
                  input mosi, input miso);
  modport slave (input sclk, input ss_n, input mosi, output s_mosi_o,
                 output s_mosi_oe_n, output s_miso_o, output s_miso_oe_n);
endinterface

// File: design/sra_device.sv
// The external register write port and the user-side strobes are this design's own decision.
module sra_device #(
  parameter logic [7:0] REVISION_VALUE = 8'h5a,  // arbitrary value
  parameter logic [31:0] HOST_VALID = sra_pkg::HOST_VALID_MAP
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  sra_spi_if.slave spi,
  input wire logic [7:0] status_bits,
  input wire logic ext_we,
  input wire logic [sra_pkg::ADDR_W-1:0] ext_addr,
  input wire logic [7:0] ext_wdata,
  output logic host_mode,
  output logic full_duplex,
  output logic reg_wr_stb,
  output logic reg_rd_stb,
  output logic [sra_pkg::ADDR_W-1:0] reg_addr,
  output logic [7:0] reg_wdata
);
  import sra_pkg::*;

  logic [2:0] sclk_q;
  logic [2:0] ss_q;
  logic [1:0] mosi_q;
  logic in_cmd_r;
  logic dir_r;
  logic drv_r;
  logic fd_frm_r;
  logic out_bit_r;
  logic [2:0] bit_cnt_r;
  logic [6:0] rx_sh_r;
  logic [ADDR_W-1:0] addr_r;
  logic [7:0] rdata_r;
  logic [7:0] stat_r;
  logic [7:0] regs_r [NUM_REGS];
  logic [7:0] reg_nxt [NUM_REGS];
  logic [7:0] rd_view [NUM_REGS];
  logic wr_stb_r;
  logic rd_stb_r;
  logic [ADDR_W-1:0] reg_addr_r;
  logic [7:0] reg_wdata_r;

  // next address after a byte
  function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] n;
    n = a;
    if (a <= REG_FIFO_LAST) begin
      n = a;
    end else if (a <= REG_INC_LAST) begin
      n = a + 5'h01;
    end else if (a == REG_IO_PINS_FIRST_BANK || a == REG_LAST) begin
      n = a;
    end else begin
      n = a + 5'h01;
    end
    return n;
  endfunction

  // pins are asynchronous to pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_q <= 3'h0;
      ss_q <= 3'h7;
      mosi_q <= 2'h0;
    end else if (clk_en) begin
      sclk_q <= {sclk_q[1:0], spi.sclk};
      ss_q <= {ss_q[1:0], spi.ss_n};
      mosi_q <= {mosi_q[0], spi.mosi};
    end
  end

  wire sel = ~ss_q[1];
  wire sel_start = ~ss_q[1] & ss_q[2];
  wire sclk_rise = sel & sclk_q[1] & ~sclk_q[2];
  wire sclk_fall = sel & ~sclk_q[1] & sclk_q[2];
  wire [7:0] rx_byte = {rx_sh_r, mosi_q[1]};
  wire byte_done = sclk_rise & (bit_cnt_r == 3'h7);
  wire cmd_done = byte_done & in_cmd_r;
  wire data_done = byte_done & ~in_cmd_r;
  wire [ADDR_W-1:0] cmd_addr = rx_byte[CMD_ADDR_MSB:CMD_ADDR_LSB];
  wire cmd_dir = rx_byte[CMD_DIR_BIT];
  wire cmd_ack = rx_byte[CMD_ACK_BIT];
  wire ack_set = cmd_done & cmd_ack & ~host_mode;
  wire [31:0] valid_map = host_mode ? HOST_VALID : PERIPH_VALID_MAP;
  wire [ADDR_W-1:0] addr_adv = next_addr(addr_r);
  wire [ADDR_W-1:0] fetch_addr = in_cmd_r ? cmd_addr : addr_adv;
  wire spi_we = data_done & dir_r & valid_map[addr_r] & ~READ_ONLY_MAP[addr_r];
  wire [7:0] tx_cur = in_cmd_r ? (fd_frm_r ? stat_r : 8'h00) : rdata_r;
  // only a read fetch or a register write moves the user-side address, so it holds to the next strobe
  wire rd_fetch = byte_done & ~(in_cmd_r ? cmd_dir : dir_r);
  wire [7:0] ack_mask = 8'(1 << ACK_BIT_POS);

  assign host_mode = regs_r[REG_OPERATING_MODE_SELECT][HOST_BIT_POS];
  assign full_duplex = regs_r[REG_PIN_CONTROL][FULL_DUPLEX_BIT_POS];
  assign spi.s_miso_o = out_bit_r;
  assign spi.s_miso_oe_n = ~(sel & fd_frm_r);
  assign spi.s_mosi_o = out_bit_r;
  assign spi.s_mosi_oe_n = ~(sel & drv_r);
  assign reg_wr_stb = wr_stb_r;
  assign reg_rd_stb = rd_stb_r;
  assign reg_addr = reg_addr_r;
  assign reg_wdata = reg_wdata_r;

  generate
    for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
      wire spi_hit = spi_we & (addr_r == ADDR_W'(i));
      wire ext_hit = ext_we & (ext_addr == ADDR_W'(i));
      wire [7:0] base = ext_hit ? ext_wdata : (spi_hit ? rx_byte : regs_r[i]);
      wire is_stall = (ADDR_W'(i) == REG_ENDPOINT_STALL_CONTROL);
      // hardware set beats any write landing in the same cycle
      assign reg_nxt[i] = (is_stall && ack_set) ? (base | ack_mask) : base;
      wire [7:0] stored = (ADDR_W'(i) == REG_REVISION) ? REVISION_VALUE : regs_r[i];
      assign rd_view[i] = valid_map[i] ? stored : 8'h00;
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_r[i] <= REG_RESET;
      end
    end else if (clk_en) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_r[i] <= reg_nxt[i];
      end
    end
  end

  // receive path and byte framing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_cmd_r <= 1'b1;
      bit_cnt_r <= 3'h0;
      rx_sh_r <= 7'h00;
      dir_r <= 1'b0;
      addr_r <= 5'h00;
    end else if (clk_en) begin
      if (sel_start) begin
        in_cmd_r <= 1'b1;
        bit_cnt_r <= 3'h0;
      end else if (sclk_rise) begin
        bit_cnt_r <= bit_cnt_r + 3'h1;
        rx_sh_r <= rx_byte[6:0];
        if (cmd_done) begin
          in_cmd_r <= 1'b0;
          dir_r <= cmd_dir;
          addr_r <= cmd_addr;
        end else if (data_done) begin
          addr_r <= addr_adv;
        end
      end
    end
  end

  // transmit path: status during command, register data after
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_bit_r <= 1'b0;
      stat_r <= 8'h00;
      rdata_r <= 8'h00;
      drv_r <= 1'b0;
      fd_frm_r <= 1'b0;
    end else if (clk_en) begin
      if (sel_start) begin
        stat_r <= status_bits;
        out_bit_r <= full_duplex & status_bits[7];
        drv_r <= 1'b0;
        // duplex mode is frozen per frame so a mid-frame write cannot move the lines
        fd_frm_r <= full_duplex;
      end else if (!sel) begin
        // a turn-around left from the last frame would clash with the next command
        drv_r <= 1'b0;
        fd_frm_r <= 1'b0;
      end else if (sclk_fall) begin
        out_bit_r <= tx_cur[~bit_cnt_r];
        // wait for the master's last command bit before turning the line
        drv_r <= ~fd_frm_r & ~in_cmd_r & ~dir_r;
      end
      if (byte_done) begin
        rdata_r <= rd_view[fetch_addr];
      end
    end
  end

  // user-side strobes so outside logic can feed and drain fifos
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_stb_r <= 1'b0;
      rd_stb_r <= 1'b0;
      reg_addr_r <= 5'h00;
      reg_wdata_r <= 8'h00;
    end else if (clk_en) begin
      wr_stb_r <= spi_we;
      rd_stb_r <= rd_fetch;
      if (spi_we) begin
        reg_addr_r <= addr_r;
        reg_wdata_r <= rx_byte;
      end else if (rd_fetch) begin
        reg_addr_r <= fetch_addr;
      end
    end
  end
endmodule

// File: design/sra_host.sv
module sra_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  sra_spi_if.master spi
);
  import sra_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_LEAD, S_HIGH, S_LOW, S_TRAIL, S_GAP} sra_hstate_type;

  sra_hstate_type state_r;
  logic [7:0] cmd_r;
  logic [2:0] nbytes_r;
  logic [31:0] data_r;
  logic half_r;
  logic [7:0] div_r;
  logic done_r;
  logic [7:0] stat_r;
  logic [7:0] sb_sh_r;
  logic [31:0] rx_r;
  logic [39:0] sh_r;
  logic [7:0] cnt_r;
  logic [2:0] bit_cnt_r;
  logic [2:0] byte_r;
  logic sclk_r;
  logic ss_n_r;
  logic oe_n_r;
  logic [31:0] prdata_r;
  logic [1:0] miso_q;
  logic [1:0] mosi_q;

  wire busy = (state_r != S_IDLE);
  wire wr_acc = psel & penable & pwrite;
  wire hit_cmd = (paddr == OFS_CMD);
  wire hit_data = (paddr == OFS_DATA);
  wire hit_cfg = (paddr == OFS_CFG);
  wire hit_stat = (paddr == OFS_STAT);
  wire hit_rx = (paddr == OFS_RX);
  wire mapped = hit_cmd | hit_data | hit_cfg | hit_stat | hit_rx;
  // command and data are locked while a frame runs
  wire start = wr_acc & hit_cmd & pwdata[CMD_START_BIT] & ~busy;
  wire [2:0] req_n = pwdata[CMD_NBYTES_LSB +: 3];
  wire [7:0] div_eff = (div_r < DIV_MIN) ? DIV_MIN : div_r;
  wire tick = (cnt_r == 8'h01);
  wire in_bit = half_r ? mosi_q[1] : miso_q[1];
  wire release_line = half_r & ~cmd_r[CMD_DIR_BIT];
  wire done_set = (state_r == S_TRAIL) & tick;
  wire done_clr = wr_acc & hit_stat & pwdata[STAT_DONE_BIT];
  wire [31:0] stat_word = {16'h0000, stat_r, 6'h00, done_r, busy};
  wire [31:0] cmd_word = {21'h00_0000, nbytes_r, cmd_r};
  wire [31:0] cfg_word = {16'h0000, div_r, 7'h00, half_r};
  wire [31:0] rd_mux = hit_cmd ? cmd_word :
                       hit_data ? data_r : hit_cfg ? cfg_word :
                       hit_stat ? stat_word : hit_rx ? rx_r : 32'h0000_0000;

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = prdata_r;
  assign spi.sclk = sclk_r;
  assign spi.ss_n = ss_n_r;
  assign spi.m_mosi_o = sh_r[39];
  assign spi.m_mosi_oe_n = oe_n_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_r <= 8'h00;
      nbytes_r <= 3'h0;
      data_r <= 32'h0000_0000;
      half_r <= 1'b0;
      div_r <= DIV_RESET;
      done_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      miso_q <= 2'h0;
      mosi_q <= 2'h0;
    end else if (clk_en) begin
      miso_q <= {miso_q[0], spi.miso};
      mosi_q <= {mosi_q[0], spi.mosi};
      if (psel & ~penable) begin
        prdata_r <= rd_mux;
      end
      if (start) begin
        cmd_r <= pwdata[7:0];
        nbytes_r <= (req_n > MAX_DATA_BYTES) ? MAX_DATA_BYTES : req_n;
      end
      if (wr_acc & hit_data & ~busy) begin
        data_r <= pwdata;
      end
      if (wr_acc & hit_cfg & ~busy) begin
        half_r <= pwdata[CFG_HALF_BIT];
        div_r <= pwdata[CFG_DIV_LSB +: 8];
      end
      done_r <= done_set | (done_r & ~done_clr);
    end
  end

  // bit engine: mode 0 clock, shift on falling, sample on rising
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= S_IDLE;
      sclk_r <= 1'b0;
      ss_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      sh_r <= 40'h00_0000_0000;
      cnt_r <= 8'h00;
      bit_cnt_r <= 3'h0;
      byte_r <= 3'h0;
      sb_sh_r <= 8'h00;
      rx_r <= 32'h0000_0000;
      stat_r <= 8'h00;
    end else if (clk_en) begin
      cnt_r <= tick ? div_eff : cnt_r - 8'h01;
      case (state_r)
        S_IDLE: begin
          cnt_r <= div_eff;
          if (start) begin
            state_r <= S_LEAD;
            ss_n_r <= 1'b0;
            oe_n_r <= 1'b0;
            sh_r <= {pwdata[7:0], data_r};
            bit_cnt_r <= 3'h0;
            byte_r <= 3'h0;
            rx_r <= 32'h0000_0000;
          end
        end
        S_LEAD, S_LOW: begin
          if (tick) begin
            sclk_r <= 1'b1;
            state_r <= S_HIGH;
            if (byte_r == 3'h0) begin
              sb_sh_r <= {sb_sh_r[6:0], in_bit};
            end else begin
              rx_r <= {rx_r[30:0], in_bit};
            end
          end
        end
        S_HIGH: begin
          if (tick) begin
            sclk_r <= 1'b0;
            sh_r <= {sh_r[38:0], 1'b0};
            bit_cnt_r <= bit_cnt_r + 3'h1;
            oe_n_r <= release_line & ((bit_cnt_r == 3'h7) | (byte_r != 3'h0));
            state_r <= S_LOW;
            if (bit_cnt_r == 3'h7) begin
              byte_r <= byte_r + 3'h1;
              if (byte_r == nbytes_r) begin
                state_r <= S_TRAIL;
              end
            end
          end
        end
        S_TRAIL: begin
          if (tick) begin
            ss_n_r <= 1'b1;
            oe_n_r <= 1'b1;
            // half duplex: the shifter only saw our own command, so report none
            stat_r <= half_r ? 8'h00 : sb_sh_r;
            state_r <= S_GAP;
          end
        end
        S_GAP: begin
          if (tick) begin
            state_r <= S_IDLE;
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end
endmodule

// File: bench/sra_spi_asserts.sv
module sra_spi_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sclk,
  input wire logic ss_n,
  input wire logic m_mosi_o,
  input wire logic m_mosi_oe_n,
  input wire logic s_mosi_o,
  input wire logic s_mosi_oe_n,
  input wire logic s_miso_o,
  input wire logic s_miso_oe_n,
  input wire logic mosi,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sclk_d_r;
  logic [7:0] bits_r;
  logic [7:0] bits_nxt;
  wire sclk_rise = sclk && !sclk_d_r;
  // rising edges counted per frame, cleared while deselected
  assign bits_nxt = ss_n ? 8'h00 : bits_r + {7'h00, sclk_rise};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_d_r <= 1'b0;
      bits_r <= 8'h00;
    end else begin
      sclk_d_r <= sclk;
      bits_r <= bits_nxt;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence frame_end;
    $rose(ss_n);
  endsequence
  sequence slave_idle;
    s_miso_oe_n && s_mosi_oe_n;
  endsequence
  idle_float_a: assert property (ss_n [*8] |-> slave_idle)
    else $error("slave drives while deselected");
  sclk_idle_a: assert property (ss_n && $past(ss_n) |-> !sclk)
    else $error("clock high while deselected");
  sclk_framed_a: assert property ($changed(sclk) |-> !ss_n)
    else $error("clock moved outside frame");
  whole_bytes_a: assert property (frame_end |-> bits_r[2:0] == 3'h0 && bits_r >= 8'h08)
    else $error("frame not whole bytes");
  select_gap_a: assert property (frame_end |=> ss_n [*7])
    else $error("select gap too short");
  sclk_high_a: assert property ($rose(sclk) |-> sclk [*8])
    else $error("clock high phase too short");
  miso_launch_a: assert property (!s_miso_oe_n && $past(!s_miso_oe_n) && $changed(s_miso_o)
    |-> !sclk)
    else $error("slave output changed while clock high");
  data_in_launch_a: assert property (!s_mosi_oe_n && $past(!s_mosi_oe_n) && $changed(s_mosi_o)
    |-> !sclk)
    else $error("slave data-in changed while clock high");
  master_launch_a: assert property (!m_mosi_oe_n && $past(!m_mosi_oe_n) && $changed(m_mosi_o)
    |-> !sclk)
    else $error("master data changed while clock high");
  lines_stable_a: assert property (sclk && $past(sclk) |-> $stable(mosi) && $stable(miso))
    else $error("data line moved while clock high");
  one_driver_a: assert property (!s_mosi_oe_n |-> m_mosi_oe_n && s_miso_oe_n)
    else $error("data-in line driven twice");
endmodule

// File: bench/tb_spi_register_access_port.sv
module tb_spi_register_access_port;
  timeunit 1ns;
  timeprecision 1ps;
  import sra_pkg::*;
  localparam logic [7:0] REV = 8'h5a;  // arbitrary value
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] status_bits = 8'h00;
  logic ext_we = 1'b0;
  logic [4:0] ext_addr = 5'h00;
  logic [7:0] ext_wdata = 8'h00;
  logic host_mode;
  logic full_duplex;
  logic reg_wr_stb;
  logic reg_rd_stb;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata;
  int n_errors = 0;
  int n_checks = 0;
  logic [7:0] mem[32];
  bit hm = 0;
  bit fd = 0;
  bit hd = 0;
  logic [31:0] rnd = 32'h279a3e0c;
  logic [31:0] rd;
  logic er;
  int n_wr = 0;
  int n_rd = 0;
  always #4 pclk = ~pclk;
  always @(posedge pclk) begin
    if (reg_wr_stb === 1'b1) n_wr++;
    if (reg_rd_stb === 1'b1) n_rd++;
  end
  sra_spi_if spi_if ();
  sra_host sra_host_inst (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .spi(spi_if));
  sra_device #(.REVISION_VALUE(REV)) sra_device_inst (.pclk(pclk), .presetn(presetn),
    .clk_en(1'b1), .spi(spi_if), .status_bits(status_bits), .ext_we(ext_we),
    .ext_addr(ext_addr), .ext_wdata(ext_wdata), .host_mode(host_mode),
    .full_duplex(full_duplex), .reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  sra_spi_asserts sra_spi_asserts_inst (.pclk(pclk), .presetn(presetn), .sclk(spi_if.sclk),
    .ss_n(spi_if.ss_n), .m_mosi_o(spi_if.m_mosi_o), .m_mosi_oe_n(spi_if.m_mosi_oe_n),
    .s_mosi_o(spi_if.s_mosi_o), .s_mosi_oe_n(spi_if.s_mosi_oe_n),
    .s_miso_o(spi_if.s_miso_o), .s_miso_oe_n(spi_if.s_miso_oe_n),
    .mosi(spi_if.mosi), .miso(spi_if.miso));
  function automatic logic [31:0] next_rnd(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic bit ok(input int a);
    logic [31:0] m;
    m = hm ? HOST_VALID_MAP : PERIPH_VALID_MAP;
    return m[a];
  endfunction
  // fifo ports, twenty and thirty-one hold; everything else steps
  function automatic int nxt(input int a);
    return (a <= 4 || a == 20 || a == 31) ? a : a + 1;
  endfunction
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_errors++;
      close_out();
    end
  endtask
  task automatic op(input logic [4:0] a, input bit dir, input bit ack, input int n,
                    input logic [31:0] d);
    logic [31:0] exp;
    logic [31:0] m;
    logic [7:0] b;
    int ad;
    int wa;
    int i;
    int nw;
    int w0;
    int r0;
    bit fd0;
    exp = 0;
    ad = a;
    wa = -1;
    nw = 0;
    w0 = n_wr;
    r0 = n_rd;
    fd0 = fd;
    rnd = next_rnd(rnd);
    status_bits <= rnd[7:0];
    // the first read byte is fetched before the ack lands, writes land after it
    if (ack && !hm && dir) mem[9] |= 8'h40;
    for (i = 0; i < n; i++) begin
      b = d[31-8*i -: 8];
      if (dir && !ok(ad)) d[31-8*i -: 8] = 8'h00;
      if (!dir) begin
        exp = {exp[23:0], !ok(ad) ? 8'h00 : (ad == 18 ? REV : mem[ad])};
      end else if (ok(ad) && ad != 18 && ad != 19) begin
        mem[ad] = b;
        wa = ad;
        nw++;
      end
      if (i == 0 && ack && !hm && !dir) mem[9] |= 8'h40;
      ad = nxt(ad);
    end
    fd = mem[17][FULL_DUPLEX_BIT_POS];
    hm = mem[27][HOST_BIT_POS];
    apb(1'b1, OFS_DATA, d);
    apb(1'b1, OFS_CMD, {15'h0, 1'b1, 5'h0, 3'(n), a, 1'b0, dir, ack});
    i = 0;
    do begin
      apb(1'b0, OFS_STAT, 32'h0);
      i++;
    // data and command writes are dropped until the select gap has passed
    end while ((rd[STAT_DONE_BIT] !== 1'b1 || rd[STAT_BUSY_BIT] !== 1'b0) && i < 500);
    if (rd[STAT_DONE_BIT] !== 1'b1 || rd[STAT_BUSY_BIT] !== 1'b0) begin
      n_errors++;
      close_out();
    end
    // free output line reads as ones when the device is half duplex
    chk("status byte", hd ? 32'h0 : (fd0 ? {24'h0, rnd[7:0]} : 32'hff), {24'h0, rd[15:8]});
    apb(1'b1, OFS_STAT, 32'h2);
    m = (n == 4) ? 32'hffffffff : (32'h1 << (8 * n)) - 32'h1;
    if (!dir) begin
      apb(1'b0, OFS_RX, 32'h0);
      chk("read data", exp & m, rd & m);
    end
    if (wa >= 0) begin
      chk("reg addr", 32'(wa), {27'h0, reg_addr});
      chk("reg wdata", {24'h0, mem[wa]}, {24'h0, reg_wdata});
    end
    chk("mode", {30'h0, hm, fd}, {30'h0, host_mode, full_duplex});
    chk("write strobes", 32'(nw), 32'(n_wr - w0));
    chk("read strobes", dir ? 32'h0 : 32'(n + 1), 32'(n_rd - r0));
  endtask
  task automatic rand_ops();
    for (int k = 0; k < 6; k++) begin
      rnd = next_rnd(rnd);
      op(5'(rnd[3:0] % 13), rnd[5], rnd[10], 1 + int'(rnd[9:8]), rnd);
    end
  endtask
  initial begin
    for (int i = 0; i < 32; i++) mem[i] = 8'h00;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    apb(1'b0, OFS_CFG, 32'h0);
    chk("cfg reset", {16'h0, DIV_RESET, 8'h00}, rd);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    op(5'h11, 1'b1, 1'b0, 1, 32'h10000000);
    op(5'h12, 1'b0, 1'b0, 3, 32'h0);
    @(posedge pclk);
    rnd = next_rnd(rnd);
    ext_we <= 1'b1;
    ext_addr <= 5'h13;
    ext_wdata <= rnd[7:0];
    mem[19] = rnd[7:0];
    @(posedge pclk);
    ext_we <= 1'b0;
    op(5'h05, 1'b1, 1'b0, 4, next_rnd(rnd));
    op(5'h05, 1'b0, 1'b0, 4, 32'h0);
    op(5'h02, 1'b1, 1'b0, 4, rnd);
    op(5'h02, 1'b0, 1'b0, 2, 32'h0);
    op(5'h12, 1'b0, 1'b0, 4, 32'h0);
    op(5'h13, 1'b1, 1'b0, 3, ~rnd);
    op(5'h14, 1'b0, 1'b0, 1, 32'h0);
    op(5'h09, 1'b0, 1'b1, 1, 32'h0);
    op(5'h09, 1'b0, 1'b0, 1, 32'h0);
    rand_ops();
    op(5'h11, 1'b1, 1'b0, 1, 32'h0);
    // divider below the floor must still give a legal clock
    apb(1'b1, OFS_CFG, 32'h0401);
    hd = 1;
    rand_ops();
    op(5'h1b, 1'b1, 1'b0, 1, 32'h01000000);
    op(5'h09, 1'b1, 1'b0, 1, 32'h0);
    op(5'h09, 1'b0, 1'b1, 1, 32'h0);
    op(5'h09, 1'b0, 1'b0, 1, 32'h0);
    op(5'h1c, 1'b1, 1'b0, 4, rnd);
    op(5'h1d, 1'b0, 1'b0, 4, 32'h0);
    op(5'h0e, 1'b0, 1'b0, 1, 32'h0);
    rand_ops();
    close_out();
  end
endmodule
